// >>> shared/swid_pkg.sv
package swid_pkg;
    // Clock rate in kHz so that microsecond figures scale exactly
    localparam int CLK_KHZ = 200000;
    localparam int CYC_PER_US = CLK_KHZ / 1000;

    // Reset low figures, microseconds
    localparam int RESET_LOW_MIN_STD_US = 480;
    localparam int RESET_LOW_MIN_FAST_US = 60;
    localparam int RESET_LOW_MAX_FAST_US = 80;
    // Presence figures, microseconds
    localparam int PRESENCE_WAIT_STD_US = 30;
    localparam int PRESENCE_WAIT_FAST_US = 3;
    localparam int PRESENCE_LOW_STD_US = 120;
    localparam int PRESENCE_LOW_FAST_US = 12;
    // Write/read slot figures, microseconds
    localparam int ZERO_WRITE_MIN_STD_US = 60;
    localparam int ZERO_WRITE_MIN_FAST_US = 6;
    localparam int ONE_WRITE_MAX_STD_US = 15;
    localparam int ONE_WRITE_MAX_FAST_US = 2;
    // Read zero hold, kept inside the master's sample window
    localparam int READ_HOLD_STD_US = 30;
    localparam int READ_HOLD_FAST_US = 3;
    localparam int POWERUP_QUIET_US = 1200;

    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] RESET_MIN_STD_CYC = CNT_W'(RESET_LOW_MIN_STD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] RESET_MIN_FAST_CYC = CNT_W'(RESET_LOW_MIN_FAST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] RESET_MAX_FAST_CYC = CNT_W'(RESET_LOW_MAX_FAST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] PRES_WAIT_STD_CYC = CNT_W'(PRESENCE_WAIT_STD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] PRES_WAIT_FAST_CYC = CNT_W'(PRESENCE_WAIT_FAST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] PRES_LOW_STD_CYC = CNT_W'(PRESENCE_LOW_STD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] PRES_LOW_FAST_CYC = CNT_W'(PRESENCE_LOW_FAST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] ZERO_MIN_STD_CYC = CNT_W'(ZERO_WRITE_MIN_STD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] ZERO_MIN_FAST_CYC = CNT_W'(ZERO_WRITE_MIN_FAST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] ONE_MAX_STD_CYC = CNT_W'(ONE_WRITE_MAX_STD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] ONE_MAX_FAST_CYC = CNT_W'(ONE_WRITE_MAX_FAST_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] READ_HOLD_STD_CYC = CNT_W'(READ_HOLD_STD_US * CYC_PER_US);
    localparam logic [CNT_W-1:0] READ_HOLD_FAST_CYC = CNT_W'(READ_HOLD_FAST_US * CYC_PER_US);
    localparam int POWERUP_QUIET_CYC = POWERUP_QUIET_US * CYC_PER_US;

    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_SEARCH_ID = 8'hf0;
    localparam logic [7:0] CMD_FAST_SKIP = 8'h3c;
    localparam int ID_BITS = 64;
    localparam logic [63:0] ID_DEFAULT = 64'h5a00_0000_0000_00a5;

    typedef enum logic [2:0]
    {
        LS_IDLE = 3'h0,
        LS_CMD = 3'h1,
        LS_READ = 3'h2,
        LS_SRCH_TRUE = 3'h3,
        LS_SRCH_COMP = 3'h4,
        LS_SRCH_PICK = 3'h5,
        LS_DONE = 3'h6
    } swid_layer_t;
endpackage : swid_pkg

// >>> shared/swid_stream_if.sv
`timescale 1ns/1ps
interface swid_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : swid_stream_if

// >>> rtl/swid_fifo.sv
`timescale 1ns/1ps
module swid_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    swid_stream_if.dst in_s,
    swid_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign in_s.ready = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data = mem[rd_ptr];
    assign do_wr = in_s.valid && in_s.ready;
    assign do_rd = out_s.valid && out_s.ready;

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : swid_fifo

// >>> rtl/swid_sync.sv
`timescale 1ns/1ps
module swid_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic stage1;

    // Idle bus is high, so both stages reset high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 1'b1;
            dout <= 1'b1;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : swid_sync

// >>> rtl/swid_link.sv
// Contract
// - Long master low is taken as reset
// - Wait, then pull low for presence
// - Long low slot decodes as zero
// - Short low slot decodes as one
// - Low time runs falling to rising edge
// - All bits travel least significant first
// - Quiet time after power-up, presence withheld
// - Only master falling edges start slots
// - Device only pulls low, open drain
// - Every low classed by duration alone
// - Order: reset, command byte, read slots
// - Commands accepted only after initialization
// - Device is always slave, never arbitrates
// - Command 33h shifts out identity number
// - Command F0h: bit, complement, match check
// - Command 3Ch sets fast speed flag
// - Long reset clears fast flag, short keeps
`timescale 1ns/1ps
module swid_link #(
    parameter logic [63:0] ID_VALUE = swid_pkg::ID_DEFAULT,
    parameter int QUIET_CYC = swid_pkg::POWERUP_QUIET_CYC,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    output logic fast_speed_flag,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    input wire logic cmd_ready,
    output logic search_dropped,
    output logic link_ready
);
    import swid_pkg::*;

    logic line_s;
    logic line_prev;
    logic low_active;
    logic [CNT_W-1:0] low_cnt;
    logic slot_end;
    logic [CNT_W-1:0] slot_len;
    logic is_reset;
    logic is_zero;
    logic is_one;
    logic pres_pend;
    logic pres_driving;
    logic [CNT_W-1:0] pres_cnt;
    logic read_drive;
    logic [CNT_W-1:0] read_cnt;
    logic [5:0] bit_idx;
    logic [2:0] cmd_bits;
    logic [7:0] cmd_shift;
    logic cmd_byte_done;
    logic [7:0] next_cmd_shift;
    logic search_active;
    logic [$clog2(QUIET_CYC+1)-1:0] quiet_cnt;
    logic quiet_done;
    logic cur_bit;
    logic fell;
    logic [CNT_W-1:0] thr_reset;
    logic [CNT_W-1:0] thr_zero;
    logic [CNT_W-1:0] thr_one;
    swid_layer_t layer;

    swid_stream_if #(.W(8)) cmd_in ();
    swid_stream_if #(.W(8)) cmd_out ();

    swid_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(line_in),
        .dout(line_s)
    );

    swid_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_s(cmd_in),
        .out_s(cmd_out)
    );

    // Thresholds follow the speed flag
    assign thr_reset = fast_speed_flag ? RESET_MIN_FAST_CYC : RESET_MIN_STD_CYC;
    assign thr_zero = fast_speed_flag ? ZERO_MIN_FAST_CYC : ZERO_MIN_STD_CYC;
    assign thr_one = fast_speed_flag ? ONE_MAX_FAST_CYC : ONE_MAX_STD_CYC;

    assign fell = line_prev && !line_s;
    assign is_reset = slot_end && (slot_len >= thr_reset);
    assign is_zero = slot_end && !is_reset && (slot_len >= thr_zero);
    // Gap between one and zero windows is read as one; master never lands there
    assign is_one = slot_end && !is_reset && (slot_len < thr_zero);
    assign cur_bit = ID_VALUE[bit_idx];
    assign next_cmd_shift = {is_zero ? 1'b0 : 1'b1, cmd_shift[7:1]};
    assign cmd_byte_done = (layer == LS_CMD) && (is_zero || is_one) && (cmd_bits == 3'h7);
    assign quiet_done = (quiet_cnt == ($clog2(QUIET_CYC+1))'(QUIET_CYC));

    assign cmd_in.valid = cmd_byte_done;
    assign cmd_in.data = next_cmd_shift;
    assign cmd_out.ready = cmd_ready && !cmd_valid;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quiet_cnt <= '0;
        end
        else if (!quiet_done)
        begin
            quiet_cnt <= quiet_cnt + 1'b1;
        end
    end

    // Low duration measurement, falling to rising edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_prev <= 1'b1;
            low_active <= 1'b0;
            low_cnt <= '0;
            slot_end <= 1'b0;
            slot_len <= '0;
        end
        else
        begin
            line_prev <= line_s;
            slot_end <= 1'b0;
            // Own pull-downs are not slots; armed only from a high line
            if (fell && !pres_driving && !read_drive && !low_active)
            begin
                low_active <= 1'b1;
                low_cnt <= CNT_W'(1);
            end
            else if (low_active && !line_s)
            begin
                if (low_cnt != '1)
                begin
                    low_cnt <= low_cnt + 1'b1;
                end
            end
            else if (low_active && line_s)
            begin
                low_active <= 1'b0;
                slot_end <= 1'b1;
                slot_len <= low_cnt;
            end
        end
    end

    // Presence answer after a reset low is released
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pres_pend <= 1'b0;
            pres_driving <= 1'b0;
            pres_cnt <= '0;
        end
        else if (is_reset && quiet_done)
        begin
            pres_pend <= 1'b1;
            pres_driving <= 1'b0;
            pres_cnt <= '0;
        end
        else if (pres_pend)
        begin
            pres_cnt <= pres_cnt + 1'b1;
            if (pres_cnt == (fast_speed_flag ? PRES_WAIT_FAST_CYC : PRES_WAIT_STD_CYC))
            begin
                pres_pend <= 1'b0;
                pres_driving <= 1'b1;
                pres_cnt <= '0;
            end
        end
        else if (pres_driving)
        begin
            pres_cnt <= pres_cnt + 1'b1;
            if (pres_cnt == (fast_speed_flag ? PRES_LOW_FAST_CYC : PRES_LOW_STD_CYC))
            begin
                pres_driving <= 1'b0;
                pres_cnt <= '0;
            end
        end
    end

    // Speed flag
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fast_speed_flag <= 1'b0;
        end
        else if (is_reset && slot_len >= RESET_MIN_STD_CYC)
        begin
            fast_speed_flag <= 1'b0;
        end
        else if (cmd_byte_done && next_cmd_shift == CMD_FAST_SKIP)
        begin
            fast_speed_flag <= 1'b1;
        end
    end

    // Transaction layer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            layer <= LS_IDLE;
            cmd_bits <= '0;
            cmd_shift <= '0;
            bit_idx <= '0;
            search_active <= 1'b0;
            search_dropped <= 1'b0;
        end
        else if (is_reset)
        begin
            // Any reset restarts the sequence; commands only after it
            layer <= quiet_done ? LS_CMD : LS_IDLE;
            cmd_bits <= '0;
            bit_idx <= '0;
            search_active <= 1'b0;
            search_dropped <= 1'b0;
        end
        else if (is_zero || is_one)
        begin
            unique case (layer)
                LS_IDLE, LS_DONE:
                begin
                    layer <= layer;
                end
                LS_CMD:
                begin
                    cmd_shift <= next_cmd_shift;
                    cmd_bits <= cmd_bits + 1'b1;
                    if (cmd_bits == 3'h7)
                    begin
                        unique case (next_cmd_shift)
                            CMD_READ_ID: layer <= LS_READ;
                            CMD_SEARCH_ID:
                            begin
                                layer <= LS_SRCH_TRUE;
                                search_active <= 1'b1;
                            end
                            default: layer <= LS_DONE;
                        endcase
                    end
                end
                LS_READ:
                begin
                    bit_idx <= bit_idx + 1'b1;
                    if (bit_idx == 6'h3f)
                    begin
                        layer <= LS_DONE;
                    end
                end
                LS_SRCH_TRUE:
                begin
                    layer <= LS_SRCH_COMP;
                end
                LS_SRCH_COMP:
                begin
                    layer <= LS_SRCH_PICK;
                end
                LS_SRCH_PICK:
                begin
                    if (is_one != cur_bit)
                    begin
                        search_active <= 1'b0;
                        search_dropped <= 1'b1;
                        layer <= LS_DONE;
                    end
                    else
                    begin
                        bit_idx <= bit_idx + 1'b1;
                        layer <= (bit_idx == 6'h3f) ? LS_DONE : LS_SRCH_TRUE;
                    end
                end
                default:
                begin
                    layer <= LS_IDLE;
                end
            endcase
        end
    end

    // Read slot drive: a zero holds the line low from the slot's falling edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_drive <= 1'b0;
            read_cnt <= '0;
        end
        else if (fell && !low_active && !pres_driving && !read_drive &&
                 ((layer == LS_READ && !cur_bit) ||
                  (layer == LS_SRCH_TRUE && search_active && !cur_bit) ||
                  (layer == LS_SRCH_COMP && search_active && cur_bit)))
        begin
            read_drive <= 1'b1;
            read_cnt <= '0;
        end
        else if (read_drive)
        begin
            read_cnt <= read_cnt + 1'b1;
            if (read_cnt == (fast_speed_flag ? READ_HOLD_FAST_CYC : READ_HOLD_STD_CYC))
            begin
                read_drive <= 1'b0;
            end
        end
    end

    // Command byte handed out through the FIFO
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_valid <= 1'b0;
            cmd_code <= '0;
        end
        else if (cmd_out.valid && cmd_out.ready)
        begin
            cmd_valid <= 1'b1;
            cmd_code <= cmd_out.data;
        end
        else if (cmd_valid && cmd_ready)
        begin
            cmd_valid <= 1'b0;
        end
    end

    // Open drain: data is always low, only the enable moves
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_out <= 1'b0;
            line_oe <= 1'b0;
            link_ready <= 1'b0;
        end
        else
        begin
            line_out <= 1'b0;
            line_oe <= pres_driving || read_drive;
            link_ready <= quiet_done && cmd_in.ready;
        end
    end
endmodule : swid_link

// >>> tb/swid_link_asserts.sv
`timescale 1ns/1ps
module swid_link_chk
    import swid_pkg::*;
#(
    parameter int QUIET_CYC = 100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic line_out,
    input wire logic line_oe,
    input wire logic fast_speed_flag,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_ready,
    input wire logic search_dropped,
    input wire logic link_ready
);
    int qcnt;
    int oe_len;
    int low_len;
    int last_low;
    int since_rise;
    int oe_at;
    logic arm_std;
    logic arm_fast;

    // Saturates so the ready check fires exactly once per reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            qcnt <= 0;
        else if (qcnt < QUIET_CYC + 8)
            qcnt <= qcnt + 1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            oe_len <= 0;
        else
            oe_len <= line_oe ? oe_len + 1 : 0;
    end

    // Raw line, so sync delay shows up as slack in the bounds
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_len <= 0;
            last_low <= 0;
        end
        else
        begin
            low_len <= line_in ? 0 : low_len + 1;
            if (line_in && low_len != 0)
                last_low <= low_len;
        end
    end

    // Presence delay counted here; a delay range this long would choke the tools
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            since_rise <= 0;
            oe_at <= 0;
            arm_std <= 1'b0;
            arm_fast <= 1'b0;
        end
        else if (line_in && low_len != 0)
        begin
            since_rise <= 0;
            oe_at <= 0;
            arm_std <= !fast_speed_flag && low_len >= int'(RESET_MIN_STD_CYC);
            arm_fast <= fast_speed_flag && low_len >= int'(RESET_MIN_FAST_CYC)
                && low_len <= int'(RESET_MAX_FAST_CYC);
        end
        else
        begin
            if (since_rise < 20000)
                since_rise <= since_rise + 1;
            if (line_oe && oe_len == 0 && oe_at == 0)
                oe_at <= since_rise;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_open_drain; line_oe |-> line_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("line driven high");
    property p_quiet; qcnt < QUIET_CYC - 2 |-> !line_oe && !link_ready; endproperty
    a_quiet: assert property (p_quiet) else $error("activity in quiet time");
    property p_ready; qcnt == QUIET_CYC + 7 |-> link_ready; endproperty
    a_ready: assert property (p_ready) else $error("link not ready after quiet time");
    property p_oe_max; line_oe |-> oe_len <= int'(PRES_LOW_STD_CYC) + 8; endproperty
    a_oe_max: assert property (p_oe_max) else $error("device low too long");
    property p_oe_min; $fell(line_oe) |-> oe_len >= int'(READ_HOLD_FAST_CYC) - 8; endproperty
    a_oe_min: assert property (p_oe_min) else $error("device low too short");
    // No presence by the window's end leaves oe_at at zero
    property p_pres_std; arm_std && since_rise == 12000 |-> oe_at >= 3000; endproperty
    a_pres_std: assert property (p_pres_std) else $error("standard presence out of window");
    property p_pres_fast; arm_fast && since_rise == 1200 |-> oe_at >= 400; endproperty
    a_pres_fast: assert property (p_pres_fast) else $error("fast presence out of window");
    property p_cmd_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code); endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped before taken");
    property p_fast_set; $rose(cmd_valid) && cmd_code == CMD_FAST_SKIP |-> ##[0:4] fast_speed_flag; endproperty
    a_fast_set: assert property (p_fast_set) else $error("fast flag not set");
    property p_fast_clear;
        $fell(fast_speed_flag) |-> low_len >= int'(RESET_MIN_STD_CYC) - 8 || last_low >= int'(RESET_MIN_STD_CYC) - 8;
    endproperty
    a_fast_clear: assert property (p_fast_clear) else $error("fast flag cleared without long reset");

    c_cmd: cover property (cmd_valid && cmd_ready);
    c_fast: cover property ($rose(fast_speed_flag));
    c_drop: cover property ($rose(search_dropped));
endmodule : swid_link_chk

bind swid_link swid_link_chk #(.QUIET_CYC(QUIET_CYC)) u_chk (.clk(clk), .rst_n(rst_n), .line_in(line_in),
    .line_out(line_out), .line_oe(line_oe), .fast_speed_flag(fast_speed_flag), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .search_dropped(search_dropped), .link_ready(link_ready));

// >>> tb/swid_master_model.sv
`timescale 1ns/1ps
module swid_master_model
    import swid_pkg::*;
(
    input wire logic clk,
    input wire logic bus,
    output logic pull_low
);
    localparam int US = CYC_PER_US;

    initial pull_low = 1'b0;

    // Master opens every slot; release leaves the line to the pull-up
    task automatic hold(input int lo, input int hi);
        @(posedge clk);
        pull_low <= 1'b1;
        repeat (lo) @(posedge clk);
        pull_low <= 1'b0;
        repeat (hi) @(posedge clk);
    endtask : hold

    task automatic reset_bus(input bit f, output logic seen);
        hold(f ? 70 * US : 500 * US, f ? 8 * US : 70 * US);
        seen = bus;
        repeat (f ? 20 * US : 200 * US) @(posedge clk);
    endtask : reset_bus

    task automatic write_bit(input bit f, input logic b);
        int lo;
        lo = b ? (f ? US * 6 / 5 : 8 * US) : (f ? 8 * US : 70 * US);
        hold(lo, (f ? 10 * US : 80 * US) - lo);
    endtask : write_bit

    // Sample well before the device's zero hold can end
    task automatic read_bit(input bit f, output logic b);
        hold(f ? US : 6 * US, f ? US / 2 : 6 * US);
        b = bus;
        repeat (f ? 8 * US : 68 * US) @(posedge clk);
    endtask : read_bit
endmodule : swid_master_model

// >>> tb/tb_swid_link.sv
`timescale 1ns/1ps
module tb_swid_link;
    import swid_pkg::*;
    localparam logic [63:0] ID = 64'h1234_5678_9abc_def1; // arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_ready = 1'b0;
    logic pull_low;
    logic line_out;
    logic line_oe;
    logic fast_speed_flag;
    logic cmd_valid;
    logic search_dropped;
    logic link_ready;
    logic [7:0] cmd_code;
    logic seen;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int n_compared = 0;
    wire logic bus = !pull_low && !(line_oe && !line_out);

    always #2.5 clk = ~clk;

    swid_link #(.ID_VALUE(ID), .QUIET_CYC(100)) uut (.clk(clk), .rst_n(rst_n), .line_in(bus),
        .line_out(line_out), .line_oe(line_oe), .fast_speed_flag(fast_speed_flag), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_ready(cmd_ready), .search_dropped(search_dropped), .link_ready(link_ready));

    swid_master_model m (.clk(clk), .bus(bus), .pull_low(pull_low));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic test_done;
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic init(input bit f, input logic flag);
        m.reset_bus(f, seen);
        check(seen, 1'b0);
        check(fast_speed_flag, flag);
    endtask : init

    task automatic send(input bit f, input logic [7:0] c);
        exp_q.push_back(c);
        for (int i = 0; i < 8; i++)
            m.write_bit(f, c[i]);
    endtask : send

    // Consumer stalls at random to exercise the command hand-off
    always @(posedge clk)
        cmd_ready <= 1'(($urandom % 4) != 0);

    always @(posedge clk)
    begin
        if (rst_n && cmd_valid && cmd_ready)
        begin
            if (exp_q.size() == 0)
                check(cmd_valid, 1'b0);
            else
                check(cmd_code, exp_q.pop_front());
        end
    end

    initial
    begin
        void'($urandom(32'h0edb));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 1000 && link_ready !== 1'b1; i++)
            @(posedge clk);
        check(link_ready, 1'b1);
        if (error_cnt != 0)
            test_done();
        // Slots before any reset must not yield a command
        for (int i = 0; i < 8; i++)
            m.write_bit(1'b1, 1'b1);
        init(1'b0, 1'b0);
        send(1'b0, CMD_FAST_SKIP);
        repeat (20) @(posedge clk);
        check(fast_speed_flag, 1'b1);
        init(1'b1, 1'b1);
        send(1'b1, CMD_READ_ID);
        for (int i = 0; i < ID_BITS; i++)
        begin
            m.read_bit(1'b1, seen);
            check(seen, ID[i]);
        end
        init(1'b1, 1'b1);
        check(search_dropped, 1'b0);
        send(1'b1, CMD_SEARCH_ID);
        // Bit 0 matches and the search goes on; bit 1 mismatches
        for (int i = 0; i < 2; i++)
        begin
            m.read_bit(1'b1, seen);
            check(seen, ID[i]);
            m.read_bit(1'b1, seen);
            check(seen, 1'(~ID[i]));
            check(search_dropped, 1'b0);
            m.write_bit(1'b1, (i == 0) ? ID[i] : !ID[i]);
        end
        repeat (20) @(posedge clk);
        check(search_dropped, 1'b1);
        init(1'b0, 1'b0);
        check(search_dropped, 1'b0);
        for (int i = 0; i < 200 && exp_q.size() != 0; i++)
            @(posedge clk);
        check(exp_q.size(), 0);
        test_done();
    end
endmodule : tb_swid_link
